// ==== shared/bfbi_pkg.sv ====
// Purpose: constants for the boot flash bus host controller
// Assumes: 250 MHz controller clock, byte-wide flash with separate pins
// Notes:   times are nanoseconds, counts are derived cycles rounded up
package bfbi_pkg;
   localparam int CLK_NS = 4;
   // flash geometry; only ADDR_W is used, the block sizes are not referenced
   localparam int ADDR_W          = 21;
   localparam int PARAM_BLK_BYTES = 8192;
   localparam int PARAM_BLK_COUNT = 8;
   localparam int MAIN_BLK_BYTES  = 65536;
   localparam int MAIN_BLK_LARGE  = 31;
   localparam int MAIN_BLK_SMALL  = 15;
   // bus timing, all least times
   localparam int T_ACC_NS       = 150;
   localparam int T_WE_LOW_NS    = 60;
   localparam int T_WE_HIGH_NS   = 40;
   localparam int T_RST_PULSE_NS = 200;
   localparam int T_WAKE_RD_NS   = 600;
   localparam int T_WAKE_WR_NS   = 1000;
   localparam int SYNC_CYC       = 2;
   localparam logic [9:0] C_ACC = 10'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
   localparam logic [9:0] C_WE_LOW = 10'((T_WE_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] C_WE_HIGH = 10'((T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] C_RST_PULSE = 10'((T_RST_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] C_WAKE_RD = 10'((T_WAKE_RD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] C_WAKE_WR = 10'((T_WAKE_WR_NS + CLK_NS - 1) / CLK_NS);
   // software register indices
   localparam logic [3:0] REG_CTRL  = 4'h0;
   localparam logic [3:0] REG_ADDR  = 4'h1;
   localparam logic [3:0] REG_WDATA = 4'h2;
   localparam logic [3:0] REG_RDATA = 4'h3;
   localparam logic [3:0] REG_STAT  = 4'h4;
   localparam int CTRL_WP_BIT  = 3;
   localparam int STAT_BUSY    = 0;
   localparam int STAT_WAKE_RD = 1;
   localparam int STAT_WAKE_WR = 2;
   localparam int STAT_ARRAY   = 3;
   localparam int STAT_REFUSED = 4;
   localparam int STAT_FAIL    = 5;
   // flash commands and status bits
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_PROG       = 8'h40;
   localparam logic [7:0] CMD_ERASE      = 8'h20;
   localparam logic [7:0] CMD_CONFIRM    = 8'hd0;
   localparam int SR_READY = 7;
   localparam int SR_ERASE_FAIL = 5;
   localparam int SR_PROG_FAIL = 4;
   localparam int SR_PROT_ERR = 1;
   typedef enum logic [2:0] {
      OP_NONE = 3'b000, OP_READ = 3'b001, OP_READ_ARRAY = 3'b010, OP_CMD = 3'b011,
      OP_PROG = 3'b100, OP_ERASE = 3'b101, OP_PDOWN = 3'b110, OP_POLL = 3'b111
   } bfbi_op_e;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_WSET = 3'b001, S_WLOW = 3'b010, S_WREL = 3'b011,
      S_RD = 3'b100, S_PD = 3'b101
   } bfbi_state_e;
endpackage : bfbi_pkg

// ==== verilog/bfbi_host.sv ====
// Purpose: host controller driving a byte-wide boot flash through its pins
// Assumes: software register port with read data one cycle after the strobe
// Notes:   one operation at a time; a start while busy is refused and flagged
// Summary of operation
// - read: select low, output enable low, write strobe and reset high
// - host waits read and write wake-up intervals after reset release
// - command write: strobe and select low, output enable high
// - host drives write protect from the CTRL bit, which cannot change while busy
// - host writes read array command before expecting array data
// - program is two writes: setup, then address and data
`timescale 1ns/1ps
`default_nettype none
module bfbi_host (
   input  wire logic                          I_MCLK,
   input  wire logic                          I_RESET,
   input  wire logic [3:0]                    I_ADDR,
   input  wire logic [31:0]                   I_WDATA,
   input  wire logic                          I_WR,
   input  wire logic                          I_RD,
   output logic      [31:0]                   O_RDATA,
   output logic      [bfbi_pkg::ADDR_W-1:0]   O_FLASH_ADDR,
   output logic                               O_CHIP_SELECT_N,
   output logic                               O_OUTPUT_ENABLE_N,
   output logic                               O_WRITE_STROBE_N,
   output logic                               O_RESET_POWERDOWN_N,
   output logic                               O_WRITE_PROTECT,
   output logic      [7:0]                    O_DATA_PINS,
   output logic                               O_DATA_PINS_OE_N,
   input  wire logic [7:0]                    I_DATA_PINS
);
   bfbi_pkg::bfbi_state_e state_r, state_nxt;
   bfbi_pkg::bfbi_op_e    op_r;
   logic [9:0]                  cnt_r, cnt_nxt;
   logic [9:0]                  wake_rd_r, wake_wr_r;
   logic [1:0]                  step_r, step_nxt;
   logic                        pend_r, pend_nxt;
   logic                        mode_array_r, mode_array_nxt;
   logic [7:0]                  byte_r, byte_nxt;
   logic [7:0]                  fdata_r, fdata_nxt;
   logic                        fail_r, fail_set;
   logic                        refused_r;
   logic                        wake_go;
   logic [7:0]                  dq_meta_r, dq_sync_r;
   logic [bfbi_pkg::ADDR_W-1:0] addr_r;
   logic [7:0]                  wdata_r;
   logic                        wp_r;

   function automatic logic [7:0] first_byte(input bfbi_pkg::bfbi_op_e op,
                                              input logic [1:0] step,
                                              input logic [7:0] wdata);
      logic [7:0] b;
      b = wdata;
      unique case (op)
         bfbi_pkg::OP_PROG:  b = (step == 2'h0) ? bfbi_pkg::CMD_PROG : wdata;
         bfbi_pkg::OP_ERASE: b = (step == 2'h0) ? bfbi_pkg::CMD_ERASE : bfbi_pkg::CMD_CONFIRM;
         bfbi_pkg::OP_READ_ARRAY: b = bfbi_pkg::CMD_READ_ARRAY;
         default:            b = wdata;
      endcase
      return b;
   endfunction : first_byte

   // counters stop at zero so a late look still sees the interval as over
   function automatic logic [9:0] dec_sat(input logic [9:0] v);
      return (v != 10'h000) ? v - 10'h001 : 10'h000;
   endfunction : dec_sat

   wire ctrl_wr_w   = I_WR && (I_ADDR == bfbi_pkg::REG_CTRL);
   wire busy_w      = pend_r || (state_r != bfbi_pkg::S_IDLE);
   wire op_given_w  = (I_WDATA[2:0] != 3'h0);
   wire launch_w    = ctrl_wr_w && op_given_w && !busy_w;
   wire refuse_w    = ctrl_wr_w && op_given_w && busy_w;
   wire stat_clr_w  = I_WR && (I_ADDR == bfbi_pkg::REG_STAT) && I_WDATA[bfbi_pkg::STAT_REFUSED];
   // wake counters hold off the first read and write after the reset pin rises
   wire rd_ok_w     = (wake_rd_r == 10'h000);
   wire wr_ok_w     = (wake_wr_r == 10'h000);
   wire is_pe_w     = (op_r == bfbi_pkg::OP_PROG) || (op_r == bfbi_pkg::OP_ERASE);
   // program data and erase confirm leave the flash showing status, whatever the byte
   wire ra_written_w = !is_pe_w && (byte_r == bfbi_pkg::CMD_READ_ARRAY);
   // array reads after any other command get a read array write first
   wire need_wr_w   = ((op_r == bfbi_pkg::OP_CMD) && (step_r == 2'h0))
                    || (is_pe_w && (step_r != 2'h2))
                    || ((op_r == bfbi_pkg::OP_READ_ARRAY) && !mode_array_r);
   wire wr_last_w   = (op_r == bfbi_pkg::OP_CMD) || (is_pe_w && (step_r == 2'h1));
   wire cnt_end_w   = (cnt_r <= 10'h001);
   wire sr_fail_w   = dq_sync_r[bfbi_pkg::SR_PROT_ERR] || dq_sync_r[bfbi_pkg::SR_PROG_FAIL]
                    || dq_sync_r[bfbi_pkg::SR_ERASE_FAIL];
   wire [7:0] stat_w = {2'h0, fail_r, refused_r, mode_array_r, !wr_ok_w, !rd_ok_w, busy_w};
   wire [31:0] rd_mux_w =
        (I_ADDR == bfbi_pkg::REG_CTRL)  ? {28'h0, wp_r, op_r} :
        (I_ADDR == bfbi_pkg::REG_ADDR)  ? {11'h0, addr_r} :
        (I_ADDR == bfbi_pkg::REG_WDATA) ? {24'h0, wdata_r} :
        (I_ADDR == bfbi_pkg::REG_RDATA) ? {24'h0, fdata_r} :
        (I_ADDR == bfbi_pkg::REG_STAT)  ? {24'h0, stat_w} : 32'h0000_0000;
   // pin levels follow the next state so every pin is a flop output
   wire wr_state_w  = (state_nxt == bfbi_pkg::S_WSET) || (state_nxt == bfbi_pkg::S_WLOW)
                    || (state_nxt == bfbi_pkg::S_WREL);
   wire ce_n_nxt    = !(wr_state_w || (state_nxt == bfbi_pkg::S_RD));
   wire oe_n_nxt    = (state_nxt != bfbi_pkg::S_RD);
   wire we_n_nxt    = (state_nxt != bfbi_pkg::S_WLOW);
   wire rp_n_nxt    = (state_nxt != bfbi_pkg::S_PD);

   always_comb begin
      state_nxt      = state_r;
      cnt_nxt        = dec_sat(cnt_r);
      step_nxt       = step_r;
      pend_nxt       = pend_r;
      byte_nxt       = byte_r;
      fdata_nxt      = fdata_r;
      mode_array_nxt = mode_array_r;
      fail_set       = 1'b0;
      wake_go        = 1'b0;
      unique case (state_r)
         bfbi_pkg::S_IDLE: begin
            if (pend_r) begin
               if (op_r == bfbi_pkg::OP_PDOWN) begin
                  state_nxt = bfbi_pkg::S_PD;
                  cnt_nxt   = bfbi_pkg::C_RST_PULSE;
               end else if (need_wr_w) begin
                  if (wr_ok_w) begin
                     state_nxt = bfbi_pkg::S_WSET;
                     byte_nxt  = first_byte(op_r, step_r, wdata_r);
                  end
               end else if (rd_ok_w) begin
                  state_nxt = bfbi_pkg::S_RD;
                  cnt_nxt   = bfbi_pkg::C_ACC;
               end
            end
         end
         bfbi_pkg::S_WSET: begin
            state_nxt = bfbi_pkg::S_WLOW;
            cnt_nxt   = bfbi_pkg::C_WE_LOW;
         end
         bfbi_pkg::S_WLOW: begin
            if (cnt_end_w) begin
               // strobe rises first so the command is latched on it
               state_nxt = bfbi_pkg::S_WREL;
               cnt_nxt   = bfbi_pkg::C_WE_HIGH;
            end
         end
         bfbi_pkg::S_WREL: begin
            if (cnt_end_w) begin
               state_nxt      = bfbi_pkg::S_IDLE;
               step_nxt       = step_r + 2'h1;
               mode_array_nxt = ra_written_w;
               if (wr_last_w) begin
                  pend_nxt = 1'b0;
               end
            end
         end
         bfbi_pkg::S_RD: begin
            if (cnt_end_w) begin
               state_nxt = bfbi_pkg::S_IDLE;
               fdata_nxt = dq_sync_r;
               // polling keeps the request open until the device reports ready
               if (!((op_r == bfbi_pkg::OP_POLL) && !dq_sync_r[bfbi_pkg::SR_READY])) begin
                  pend_nxt = 1'b0;
               end
               fail_set = (op_r == bfbi_pkg::OP_POLL) && dq_sync_r[bfbi_pkg::SR_READY]
                        && sr_fail_w;
            end
         end
         bfbi_pkg::S_PD: begin
            if (cnt_end_w) begin
               state_nxt      = bfbi_pkg::S_IDLE;
               pend_nxt       = 1'b0;
               wake_go        = 1'b1;
               mode_array_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = bfbi_pkg::S_IDLE;
         end
      endcase
      if (launch_w) begin
         pend_nxt = 1'b1;
         step_nxt = 2'h0;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
         // reset holds the flash in power-down for a full pulse width
         state_r      <= bfbi_pkg::S_PD;
         cnt_r        <= bfbi_pkg::C_RST_PULSE;
         step_r       <= 2'h0;
         pend_r       <= 1'b0;
         byte_r       <= 8'h00;
         fdata_r      <= 8'h00;
         mode_array_r <= 1'b1;
      end else begin
         state_r      <= state_nxt;
         cnt_r        <= cnt_nxt;
         step_r       <= step_nxt;
         pend_r       <= pend_nxt;
         byte_r       <= byte_nxt;
         fdata_r      <= fdata_nxt;
         mode_array_r <= mode_array_nxt;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
         wake_rd_r <= 10'h000;
         wake_wr_r <= 10'h000;
      end else if (wake_go) begin
         wake_rd_r <= bfbi_pkg::C_WAKE_RD;
         wake_wr_r <= bfbi_pkg::C_WAKE_WR;
      end else begin
         wake_rd_r <= dec_sat(wake_rd_r);
         wake_wr_r <= dec_sat(wake_wr_r);
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
         op_r    <= bfbi_pkg::OP_NONE;
         addr_r  <= '0;
         wdata_r <= 8'h00;
         wp_r    <= 1'b0;
      end else begin
         if (launch_w) begin
            op_r <= bfbi_pkg::bfbi_op_e'(I_WDATA[2:0]);
         end
         // protect level may not move under a running operation
         if (ctrl_wr_w && !busy_w) begin
            wp_r <= I_WDATA[bfbi_pkg::CTRL_WP_BIT];
         end
         if (I_WR && (I_ADDR == bfbi_pkg::REG_ADDR) && !busy_w) begin
            addr_r <= I_WDATA[bfbi_pkg::ADDR_W-1:0];
         end
         if (I_WR && (I_ADDR == bfbi_pkg::REG_WDATA) && !busy_w) begin
            wdata_r <= I_WDATA[7:0];
         end
      end
   end

   // sticky flags: a new event in the clearing cycle wins
   always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
         refused_r <= 1'b0;
         fail_r    <= 1'b0;
      end else begin
         refused_r <= refuse_w || (refused_r && !stat_clr_w);
         fail_r    <= fail_set || (fail_r && !stat_clr_w);
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
         dq_meta_r <= 8'h00;
         dq_sync_r <= 8'h00;
      end else begin
         dq_meta_r <= I_DATA_PINS;
         dq_sync_r <= dq_meta_r;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
         O_RDATA             <= 32'h0000_0000;
         O_FLASH_ADDR        <= '0;
         O_CHIP_SELECT_N     <= 1'b1;
         O_OUTPUT_ENABLE_N   <= 1'b1;
         O_WRITE_STROBE_N    <= 1'b1;
         O_RESET_POWERDOWN_N <= 1'b0;
         O_WRITE_PROTECT     <= 1'b0;
         O_DATA_PINS         <= 8'h00;
         O_DATA_PINS_OE_N    <= 1'b1;
      end else begin
         if (I_RD) begin
            O_RDATA <= rd_mux_w;
         end
         O_FLASH_ADDR        <= addr_r;
         O_CHIP_SELECT_N     <= ce_n_nxt;
         O_OUTPUT_ENABLE_N   <= oe_n_nxt;
         O_WRITE_STROBE_N    <= we_n_nxt;
         O_RESET_POWERDOWN_N <= rp_n_nxt;
         O_WRITE_PROTECT     <= wp_r;
         O_DATA_PINS         <= byte_nxt;
         O_DATA_PINS_OE_N    <= !wr_state_w;
      end
   end
endmodule : bfbi_host
`default_nettype wire

// ==== test/bfbi_host_monitor.sv ====
// Purpose: pin protocol checks on the flash host controller
// Assumes: one clock, synchronous reset active high
// Notes:   wake and pulse margins allow one cycle for the pin flop
`timescale 1ns/1ps
`default_nettype none
module bfbi_host_monitor (
   input wire logic                        I_MCLK,
   input wire logic                        I_RESET,
   input wire logic [bfbi_pkg::ADDR_W-1:0] O_FLASH_ADDR,
   input wire logic                        O_CHIP_SELECT_N,
   input wire logic                        O_OUTPUT_ENABLE_N,
   input wire logic                        O_WRITE_STROBE_N,
   input wire logic                        O_RESET_POWERDOWN_N,
   input wire logic                        O_WRITE_PROTECT,
   input wire logic [7:0]                  O_DATA_PINS,
   input wire logic                        O_DATA_PINS_OE_N
);
   // cycles since the reset pin went high or low, saturating
   logic [9:0] hi_cnt_r;
   logic [9:0] lo_cnt_r;
   always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
         hi_cnt_r <= 10'h000;
         lo_cnt_r <= 10'h000;
      end else begin
         hi_cnt_r <= !O_RESET_POWERDOWN_N ? 10'h000 : hi_cnt_r + {9'h000, hi_cnt_r != 10'h3ff};
         lo_cnt_r <= O_RESET_POWERDOWN_N ? 10'h000 : lo_cnt_r + {9'h000, lo_cnt_r != 10'h3ff};
      end
   end
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_RESET);
   property p_read_ctl;
      !O_OUTPUT_ENABLE_N |-> !O_CHIP_SELECT_N && O_WRITE_STROBE_N && O_RESET_POWERDOWN_N;
   endproperty
   a_read_ctl: assert property (p_read_ctl) else $error("read without proper controls");
   property p_no_fight;
      !O_DATA_PINS_OE_N |-> O_OUTPUT_ENABLE_N;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("host drives while flash outputs");
   property p_pdown_quiet;
      !O_RESET_POWERDOWN_N |-> O_CHIP_SELECT_N && O_WRITE_STROBE_N && O_OUTPUT_ENABLE_N;
   endproperty
   a_pdown_quiet: assert property (p_pdown_quiet) else $error("strobe in power-down");
   property p_wr_ctl;
      !O_WRITE_STROBE_N |-> !O_CHIP_SELECT_N && O_OUTPUT_ENABLE_N && !O_DATA_PINS_OE_N;
   endproperty
   a_wr_ctl: assert property (p_wr_ctl) else $error("write strobe with bad controls");
   property p_wr_hold;
      $rose(O_WRITE_STROBE_N) |-> !O_CHIP_SELECT_N && !O_DATA_PINS_OE_N
         && $stable(O_DATA_PINS) && $stable(O_FLASH_ADDR);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("data moved at strobe rise");
   property p_we_width;
      $fell(O_WRITE_STROBE_N) |-> !O_WRITE_STROBE_N [*8] ##7 !O_WRITE_STROBE_N;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write strobe too short");
   property p_wake_rd;
      !O_OUTPUT_ENABLE_N |-> hi_cnt_r >= bfbi_pkg::C_WAKE_RD - 10'h001;
   endproperty
   a_wake_rd: assert property (p_wake_rd) else $error("read too soon after wake");
   property p_wake_wr;
      !O_WRITE_STROBE_N |-> hi_cnt_r >= bfbi_pkg::C_WAKE_WR - 10'h001;
   endproperty
   a_wake_wr: assert property (p_wake_wr) else $error("write too soon after wake");
   property p_rst_pulse;
      $rose(O_RESET_POWERDOWN_N) |-> lo_cnt_r >= bfbi_pkg::C_RST_PULSE - 10'h001;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");
   property p_wp_stable;
      !O_WRITE_STROBE_N |-> $stable(O_WRITE_PROTECT);
   endproperty
   a_wp_stable: assert property (p_wp_stable) else $error("protect moved in write");
endmodule : bfbi_host_monitor
`default_nettype wire

// ==== test/bfbi_flash_model.sv ====
// Purpose: behavioural byte-wide boot flash facing the host controller
// Assumes: program and erase finish at once, so status is always ready
// Notes:   bottom boot layout; released data lines toggle every clock
`timescale 1ns/1ps
`default_nettype none
module bfbi_flash_model #(
   parameter logic [7:0] MFR_CODE = 8'h5a, // arbitrary value
   parameter logic [7:0] DEV_CODE = 8'h3c, // arbitrary value
   parameter bit         VPP_OK   = 1'b1
) (
   input  wire logic        i_clk,
   input  wire logic [20:0] i_addr,
   input  wire logic        i_ce_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_we_n,
   input  wire logic        i_rp_n,
   input  wire logic        i_wp,
   input  wire logic [7:0]  i_dq,
   output logic      [7:0]  o_dq
);
   logic [7:0] mem [int];
   logic [7:0] sr_r   = 8'h80;
   logic [7:0] pend_r = 8'h00;
   logic [1:0] mode_r = 2'd0; // 0 array, 1 identifier, 2 status
   logic [7:0] junk_r = 8'h00;
   logic [7:0] rd_r   = 8'h00;
   int         key;
   function automatic int blk(input int a);
      return (a < 65536) ? (a >> 13) : (7 + (a >> 16));
   endfunction : blk
   always @(posedge i_we_n or negedge i_rp_n) begin
      if (!i_rp_n) begin
         sr_r = 8'h80;
         pend_r = 8'h00;
         mode_r = 2'd0;
      end else if (!i_ce_n && i_oe_n) begin
         if (pend_r == 8'h40) begin
            if (i_addr < 16384 && !i_wp) sr_r = sr_r | 8'h12;
            else mem[i_addr] = (mem.exists(i_addr) ? mem[i_addr] : 8'hff) & i_dq;
            pend_r = 8'h00;
         end else if (pend_r == 8'h20) begin
            if (i_dq != 8'hd0) sr_r = sr_r | 8'h30;
            else if (i_addr < 16384 && !i_wp) sr_r = sr_r | 8'h22;
            else if (mem.first(key)) do if (blk(key) == blk(i_addr)) mem[key] = 8'hff;
               while (mem.next(key));
            pend_r = 8'h00;
         end else case (i_dq)
            8'hff: mode_r = 2'd0;
            8'h90: mode_r = 2'd1;
            8'h70: mode_r = 2'd2;
            8'h50: sr_r = 8'h80;
            8'h40, 8'h20: begin
               if (VPP_OK) pend_r = i_dq;
               else sr_r = sr_r | 8'h08;
               mode_r = 2'd2;
            end
            default: ;
         endcase
      end
   end
   always @(posedge i_clk) begin
      junk_r <= junk_r + 8'h9d;
      if (mode_r == 2'd0) rd_r <= mem.exists(i_addr) ? mem[i_addr] : 8'hff;
      else if (mode_r == 2'd1) rd_r <= i_addr[0] ? DEV_CODE : MFR_CODE;
      else rd_r <= sr_r;
   end
   // a released bus shows garbage so a stale value cannot pass for a read
   assign o_dq = (!i_ce_n && !i_oe_n && i_we_n && i_rp_n) ? rd_r : junk_r;
endmodule : bfbi_flash_model
`default_nettype wire

// ==== test/bfbi_host_tb.sv ====
// Purpose: self-checking bench for the boot flash host controller
// Assumes: register read data stands one cycle after the strobe
// Notes:   status polling reads carry no note and are not compared
`timescale 1ns/1ps
`default_nettype none
module bfbi_host_tb;
   logic        I_MCLK = 1'b0, I_RESET = 1'b1, I_WR = 1'b0, I_RD = 1'b0;
   logic [3:0]  I_ADDR = 4'h0;
   logic [31:0] I_WDATA = 32'h0, O_RDATA;
   logic [20:0] O_FLASH_ADDR, a;
   logic        O_CHIP_SELECT_N, O_OUTPUT_ENABLE_N, O_WRITE_STROBE_N, O_RESET_POWERDOWN_N;
   logic        O_WRITE_PROTECT, O_DATA_PINS_OE_N, chk_now = 1'b0, rd_seen = 1'b0;
   logic [7:0]  O_DATA_PINS, I_DATA_PINS, d;
   logic [7:0]  cmds [3] = '{8'h90, 8'h90, 8'h70};
   logic [7:0]  ids [3] = '{8'h5a, 8'h3c, 8'h80};
   logic [31:0] exp_q [$];
   int          n_fail = 0, checked = 0, seed = 34623;
   bfbi_host dut (.I_MCLK, .I_RESET, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_FLASH_ADDR,
      .O_CHIP_SELECT_N, .O_OUTPUT_ENABLE_N, .O_WRITE_STROBE_N, .O_RESET_POWERDOWN_N,
      .O_WRITE_PROTECT, .O_DATA_PINS, .O_DATA_PINS_OE_N, .I_DATA_PINS);
   bfbi_flash_model #(.MFR_CODE(8'h5a), .DEV_CODE(8'h3c), .VPP_OK(1'b1)) flash (.i_clk(I_MCLK),
      .i_addr(O_FLASH_ADDR), .i_ce_n(O_CHIP_SELECT_N), .i_oe_n(O_OUTPUT_ENABLE_N),
      .i_we_n(O_WRITE_STROBE_N), .i_rp_n(O_RESET_POWERDOWN_N), .i_wp(O_WRITE_PROTECT),
      .i_dq(O_DATA_PINS), .o_dq(I_DATA_PINS));
   always #2 I_MCLK = ~I_MCLK;
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t read %h expected %h", $time, got, exp);
      end
   endtask : cmp32
   always @(posedge I_MCLK) begin
      rd_seen <= I_RD && chk_now;
      if (rd_seen) cmp32(O_RDATA, exp_q.pop_front());
   end
   task automatic wr(input logic [3:0] ad, input logic [31:0] v);
      I_ADDR <= ad;
      I_WDATA <= v;
      I_WR <= 1'b1;
      @(posedge I_MCLK);
      I_WR <= 1'b0;
      @(posedge I_MCLK);
   endtask : wr
   task automatic rd(input logic [3:0] ad, input logic [31:0] e, input bit c);
      I_ADDR <= ad;
      I_RD <= 1'b1;
      chk_now <= c;
      if (c) exp_q.push_back(e);
      @(posedge I_MCLK);
      I_RD <= 1'b0;
      @(posedge I_MCLK);
   endtask : rd
   task automatic wait_idle();
      for (int i = 0; i < 2000; i++) begin
         rd(bfbi_pkg::REG_STAT, 32'h0, 1'b0);
         if (O_RDATA[2:0] === 3'b000) break;
      end
      if (O_RDATA[2:0] !== 3'b000) begin
         n_fail++;
         $display("BAD t=%0t controller stayed busy", $time);
      end
   endtask : wait_idle
   task automatic cmd_rd(input logic [7:0] c, input logic [31:0] e);
      wr(bfbi_pkg::REG_WDATA, {24'h0, c});
      wr(bfbi_pkg::REG_CTRL, 32'hb);
      wait_idle();
      wr(bfbi_pkg::REG_CTRL, 32'h9);
      wait_idle();
      rd(bfbi_pkg::REG_RDATA, e, 1'b1);
   endtask : cmd_rd
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge I_MCLK);
      I_RESET <= 1'b0;
      wait_idle();
      rd(bfbi_pkg::REG_STAT, 32'h8, 1'b1);
      rd(4'hf, 32'h0, 1'b1);
      $display("test wake done");
      repeat (2) begin
         a = 21'h10000 + 21'($random(seed) & 32'hffff);
         d = 8'($random(seed));
         wr(bfbi_pkg::REG_ADDR, 32'(a));
         wr(bfbi_pkg::REG_WDATA, {24'h0, d});
         I_ADDR <= bfbi_pkg::REG_CTRL;
         I_WDATA <= 32'hc;
         I_WR <= 1'b1;
         @(posedge I_MCLK);
         I_WDATA <= 32'h9;
         @(posedge I_MCLK);
         I_WR <= 1'b0;
         wait_idle();
         rd(bfbi_pkg::REG_STAT, 32'h10, 1'b1);
         wr(bfbi_pkg::REG_STAT, 32'h10);
         wr(bfbi_pkg::REG_CTRL, 32'ha);
         wait_idle();
         rd(bfbi_pkg::REG_CTRL, 32'ha, 1'b1);
         rd(bfbi_pkg::REG_RDATA, {24'h0, d}, 1'b1);
      end
      $display("test program done");
      for (int i = 0; i < 3; i++) begin
         wr(bfbi_pkg::REG_ADDR, 32'(i == 1));
         cmd_rd(cmds[i], {24'h0, ids[i]});
      end
      $display("test identifier done");
      wr(bfbi_pkg::REG_ADDR, 32'h100);
      wr(bfbi_pkg::REG_CTRL, 32'h5);
      wait_idle();
      wr(bfbi_pkg::REG_CTRL, 32'h7);
      wait_idle();
      rd(bfbi_pkg::REG_STAT, 32'h20, 1'b1);
      cmd_rd(8'h70, 32'ha2);
      wr(bfbi_pkg::REG_STAT, 32'h10);
      $display("test locked erase done");
      wr(bfbi_pkg::REG_CTRL, 32'he);
      wait_idle();
      rd(bfbi_pkg::REG_STAT, 32'h8, 1'b1);
      wr(bfbi_pkg::REG_ADDR, 32'(a));
      wr(bfbi_pkg::REG_CTRL, 32'h9);
      wait_idle();
      rd(bfbi_pkg::REG_RDATA, {24'h0, d}, 1'b1);
      cmd_rd(8'h70, 32'h80);
      $display("test power-down done");
      report_and_stop();
   end
endmodule : bfbi_host_tb
bind bfbi_host bfbi_host_monitor u_mon (.I_MCLK, .I_RESET, .O_FLASH_ADDR, .O_CHIP_SELECT_N,
   .O_OUTPUT_ENABLE_N, .O_WRITE_STROBE_N, .O_RESET_POWERDOWN_N, .O_WRITE_PROTECT,
   .O_DATA_PINS, .O_DATA_PINS_OE_N);
`default_nettype wire
